// ==== hdl/tccfg_defs.svh ====
// Register offsets, field positions, reset values and timing for the timer control block
`ifndef TCCFG_DEFS_SVH
`define TCCFG_DEFS_SVH
`define TCCFG_OFF_CLK 4'h0
`define TCCFG_OFF_WAVE 4'h1
`define TCCFG_OFF_CMP 4'h2
`define TCCFG_OFF_EVT 4'h3
`define TCCFG_OFF_CMD 4'h4
`define TCCFG_OFF_PER 4'h5
`define TCCFG_OFF_CCA 4'h6
`define TCCFG_OFF_CNT 4'h7
`define TCCFG_OFF_STAT 4'h8
`define TCCFG_CMD_RESTART_BIT 1
`define TCCFG_CTRL_RESET 8'h00
`define TCCFG_PER_RESET 16'hFFFF
`define TCCFG_EVT_DELAY_CYC 1
`endif

// ==== hdl/tccfg_pkg.sv ====
// Types shared by the timer control block
package tccfg_pkg;
   typedef enum logic [2:0] {
      TCCFG_WM_NORMAL = 3'h0, TCCFG_WM_FREQ = 3'h1, TCCFG_WM_ONE_RAMP = 3'h3,
      TCCFG_WM_TWO_TOP = 3'h5, TCCFG_WM_TWO_BOTH = 3'h6, TCCFG_WM_TWO_BOTTOM = 3'h7
   } tccfg_wave_e;
   typedef enum logic [2:0] {
      TCCFG_EA_NONE = 3'h0, TCCFG_EA_CAPTURE = 3'h1, TCCFG_EA_DIRECTION = 3'h2,
      TCCFG_EA_QUADRATURE = 3'h3, TCCFG_EA_RESTART = 3'h4, TCCFG_EA_FREQ_INPUT_CAPTURE_ACTION = 3'h5,
      TCCFG_EA_PULSE_WIDTH = 3'h6
   } tccfg_action_e;
   typedef struct packed {
      logic [3:0] channel_enable;
      logic [2:0] wave_mode;
      logic [3:0] direct_output_value;
      logic [2:0] event_action;
      logic event_delay;
      logic [3:0] event_source_sel;
      logic [3:0] clock_source_sel;
   } tccfg_ctrl_s;
endpackage

// ==== hdl/tccfg_prescaler.sv ====
// Free-running prescaler giving one-cycle ticks for the seven division ratios
`timescale 1ns/1ps
module tccfg_prescaler #(
   parameter int WIDTH = 10
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control
   input wire logic run,
   input wire logic [3:0] sel,
   // Tick
   output logic tick
);
   logic [WIDTH-1:0] div_reg;
   logic hit;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_reg <= '0;
      end else if (run) begin
         div_reg <= div_reg + 1'b1;
      end else begin
         div_reg <= '0;
      end
   end

   always_comb begin
      case (sel)
         4'h1: hit = 1'b1;
         4'h2: hit = &div_reg[0:0];
         4'h3: hit = &div_reg[1:0];
         4'h4: hit = &div_reg[2:0];
         4'h5: hit = &div_reg[5:0];
         4'h6: hit = &div_reg[7:0];
         4'h7: hit = &div_reg[9:0];
         default: hit = 1'b0;
      endcase
   end

   assign tick = run && hit;
endmodule

// ==== hdl/tccfg_event_route.sv ====
// Event channel routing: selected channel plus per-capture-channel rotation
`timescale 1ns/1ps
module tccfg_event_route (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Selection
   input wire logic [3:0] source_sel,
   input wire logic [2:0] action,
   input wire logic delay,
   // Events
   input wire logic [7:0] events,
   output logic [3:0] chan_event,
   output logic main_event
);
   logic [3:0] raw;
   logic [3:0] dly_reg;
   logic [7:0] prev_reg;
   logic [7:0] rise;
   logic active;

   // Low source codes and the none/reserved actions route nothing
   assign active = source_sel[3] && (action != 3'h0) && (action != 3'h7);
   // Channels carry levels; one event per rising edge, not one per cycle held
   assign rise = events & ~prev_reg;

   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_rot
         logic [2:0] idx;
         assign idx = source_sel[2:0] + 3'(i);
         assign raw[i] = active && rise[idx];
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dly_reg <= '0;
         prev_reg <= '0;
      end else begin
         dly_reg <= raw;
         prev_reg <= events;
      end
   end

   // Delayed copy is gated too, so no stale edge leaks once routing turns inactive
   assign chan_event = (delay ? dly_reg : raw) & {4{active}};
   assign main_event = chan_event[0];
endmodule

// ==== hdl/tccfg_top.sv ====
// Timer control registers with counter, waveform generator and event routing
`timescale 1ns/1ps
`include "tccfg_defs.svh"
module tccfg_top (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // Register port
   input wire logic [3:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [15:0] RDATA,
   // Events and port
   input wire logic [7:0] EVENT_CH,
   input wire logic [3:0] PORT_OUT,
   output logic [3:0] WAVE_OUTPUT_PIN,
   output logic OVERFLOW_EVENT,
   output logic [3:0] CAPTURE_EVENT
);
   logic rst_meta_reg, rst_n_reg;
   logic [7:0] ev_meta_reg, ev_sync_reg;
   tccfg_pkg::tccfg_ctrl_s ctrl_reg;
   logic [15:0] per_reg, cca_reg, cnt_reg;
   logic [15:0] cap_reg [4];
   logic [3:0] capv_reg;
   logic dir_reg, error_flag_reg, overflow_flag_reg;
   logic [3:0] wg_reg;
   logic [3:0] pin_reg, input_capture_action_out_reg;
   logic ovf_out_reg;
   logic pre_tick, cnt_tick, running, is_capture, restart;
   logic [15:0] top;
   logic at_top, at_bottom, flag_point;
   logic [3:0] chan_event;
   logic main_event;
   tccfg_pkg::tccfg_wave_e wmode;

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg <= rst_meta_reg;
      end
   end

   always_ff @(posedge CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         ev_meta_reg <= '0;
         ev_sync_reg <= '0;
      end else begin
         ev_meta_reg <= EVENT_CH;
         ev_sync_reg <= ev_meta_reg;
      end
   end

   // Control register writes, upper bits dropped so they read zero
   always_ff @(posedge CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         ctrl_reg <= '0;
         per_reg <= `TCCFG_PER_RESET;
         cca_reg <= '0;
      end else if (WR) begin
         case (ADDR)
            `TCCFG_OFF_CLK: ctrl_reg.clock_source_sel <= WDATA[3:0];
            `TCCFG_OFF_WAVE: begin
               ctrl_reg.channel_enable <= WDATA[7:4];
               ctrl_reg.wave_mode <= WDATA[2:0];
            end
            `TCCFG_OFF_CMP: ctrl_reg.direct_output_value <= WDATA[3:0];
            `TCCFG_OFF_EVT: begin
               ctrl_reg.event_action <= WDATA[7:5];
               ctrl_reg.event_delay <= WDATA[4];
               ctrl_reg.event_source_sel <= WDATA[3:0];
            end
            `TCCFG_OFF_PER: per_reg <= WDATA;
            `TCCFG_OFF_CCA: cca_reg <= WDATA;
            default: ;
         endcase
      end
   end

   assign restart = WR && (ADDR == `TCCFG_OFF_CMD) && WDATA[`TCCFG_CMD_RESTART_BIT];
   assign running = ctrl_reg.clock_source_sel != 4'h0;

   tccfg_prescaler #(.WIDTH(10)) u_pre (
      .clk(CLK),
      .rst_n(rst_n_reg),
      .run(running && !ctrl_reg.clock_source_sel[3]),
      .sel(ctrl_reg.clock_source_sel),
      .tick(pre_tick)
   );

   tccfg_event_route u_route (
      .clk(CLK),
      .rst_n(rst_n_reg),
      .source_sel(ctrl_reg.event_source_sel),
      .action(ctrl_reg.event_action),
      .delay(ctrl_reg.event_delay),
      .events(ev_sync_reg),
      .chan_event(chan_event),
      .main_event(main_event)
   );

   // Event clock counts on the synchronised channel level's rising edge
   logic [7:0] ev_prev_reg;
   always_ff @(posedge CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         ev_prev_reg <= '0;
      end else begin
         ev_prev_reg <= ev_sync_reg;
      end
   end
   assign cnt_tick = ctrl_reg.clock_source_sel[3] ?
      (ev_sync_reg[ctrl_reg.clock_source_sel[2:0]] && !ev_prev_reg[ctrl_reg.clock_source_sel[2:0]])
      : pre_tick;

   // Reserved wave codes fall back to normal
   always_comb begin
      case (ctrl_reg.wave_mode)
         3'h1: wmode = tccfg_pkg::TCCFG_WM_FREQ;
         3'h3: wmode = tccfg_pkg::TCCFG_WM_ONE_RAMP;
         3'h5: wmode = tccfg_pkg::TCCFG_WM_TWO_TOP;
         3'h6: wmode = tccfg_pkg::TCCFG_WM_TWO_BOTH;
         3'h7: wmode = tccfg_pkg::TCCFG_WM_TWO_BOTTOM;
         default: wmode = tccfg_pkg::TCCFG_WM_NORMAL;
      endcase
   end

   assign is_capture = (ctrl_reg.event_action == tccfg_pkg::TCCFG_EA_CAPTURE) ||
      (ctrl_reg.event_action == tccfg_pkg::TCCFG_EA_FREQ_INPUT_CAPTURE_ACTION) ||
      (ctrl_reg.event_action == tccfg_pkg::TCCFG_EA_PULSE_WIDTH);
   assign top = (wmode == tccfg_pkg::TCCFG_WM_FREQ) ? cca_reg : per_reg;
   assign at_top = cnt_tick && (dir_reg ? 1'b0 : (cnt_reg >= top));
   // Bottom is left from zero, so top and bottom sit half a period apart
   assign at_bottom = cnt_tick && dir_reg && (cnt_reg == 16'h0000);

   logic two_ramp;
   assign two_ramp = wmode[2];

   // Flag and update points per wave mode
   always_comb begin
      case (wmode)
         tccfg_pkg::TCCFG_WM_NORMAL: flag_point = at_top;
         tccfg_pkg::TCCFG_WM_FREQ: flag_point = at_top;
         tccfg_pkg::TCCFG_WM_ONE_RAMP: flag_point = at_top;
         tccfg_pkg::TCCFG_WM_TWO_TOP: flag_point = at_top;
         tccfg_pkg::TCCFG_WM_TWO_BOTH: flag_point = at_top || at_bottom;
         tccfg_pkg::TCCFG_WM_TWO_BOTTOM: flag_point = at_bottom;
         default: flag_point = at_top;
      endcase
   end

   // Counter and direction; one-ramp wrap to zero is its top point
   always_ff @(posedge CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         cnt_reg <= '0;
         dir_reg <= 1'b0;
      end else if (restart) begin
         cnt_reg <= '0;
         dir_reg <= 1'b0;
      end else if (ctrl_reg.event_action == tccfg_pkg::TCCFG_EA_RESTART && main_event) begin
         cnt_reg <= '0;
         dir_reg <= 1'b0;
      end else if (cnt_tick) begin
         if (two_ramp) begin
            if (at_top) begin
               dir_reg <= 1'b1;
               cnt_reg <= cnt_reg - 16'h0001;
            end else if (at_bottom) begin
               dir_reg <= 1'b0;
               cnt_reg <= 16'h0001;
            end else begin
               cnt_reg <= dir_reg ? cnt_reg - 16'h0001 : cnt_reg + 16'h0001;
            end
         end else if (ctrl_reg.event_action == tccfg_pkg::TCCFG_EA_DIRECTION && main_event) begin
            cnt_reg <= cnt_reg - 16'h0001;
         end else begin
            cnt_reg <= at_top ? 16'h0000 : cnt_reg + 16'h0001;
         end
      end
   end

   // Waveform generator outputs
   always_ff @(posedge CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         wg_reg <= '0;
      end else if (restart) begin
         wg_reg <= '0;
      end else if (!running) begin
         // Only a write loads them, so a restart while off leaves them cleared
         if (WR && ADDR == `TCCFG_OFF_CMP) begin
            wg_reg <= WDATA[3:0];
         end
      end else if (cnt_tick) begin
         case (wmode)
            tccfg_pkg::TCCFG_WM_FREQ: if (at_top) wg_reg[0] <= ~wg_reg[0];
            tccfg_pkg::TCCFG_WM_ONE_RAMP: wg_reg <= at_top ? 4'h0 : 4'hF;
            tccfg_pkg::TCCFG_WM_NORMAL: wg_reg <= wg_reg;
            default: wg_reg <= at_bottom ? 4'hF : (at_top ? 4'h0 : wg_reg);
         endcase
      end
   end

   // Capture of count into per-channel slots
   genvar c;
   generate
      for (c = 0; c < 4; c++) begin : g_cap
         always_ff @(posedge CLK or negedge rst_n_reg) begin
            if (!rst_n_reg) begin
               cap_reg[c] <= '0;
               capv_reg[c] <= 1'b0;
            end else if (is_capture && ctrl_reg.channel_enable[c] && chan_event[c]) begin
               cap_reg[c] <= cnt_reg;
               capv_reg[c] <= 1'b1;
            end else if (RD && ADDR == `TCCFG_OFF_STAT) begin
               capv_reg[c] <= 1'b0;
            end
         end
      end
   endgenerate

   // Sticky flags: hardware set beats read clear
   logic [3:0] cap_hit;
   assign cap_hit = {4{is_capture}} & ctrl_reg.channel_enable & chan_event;
   always_ff @(posedge CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         error_flag_reg <= 1'b0;
         overflow_flag_reg <= 1'b0;
      end else begin
         if (|(cap_hit & capv_reg)) begin
            error_flag_reg <= 1'b1;
         end else if (RD && ADDR == `TCCFG_OFF_STAT) begin
            error_flag_reg <= 1'b0;
         end
         if (flag_point) begin
            overflow_flag_reg <= 1'b1;
         end else if (RD && ADDR == `TCCFG_OFF_STAT) begin
            overflow_flag_reg <= 1'b0;
         end
      end
   end

   // Pin override only in waveform modes
   always_ff @(posedge CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         pin_reg <= '0;
         ovf_out_reg <= 1'b0;
         input_capture_action_out_reg <= '0;
      end else begin
         for (int k = 0; k < 4; k++) begin
            pin_reg[k] <= (wmode != tccfg_pkg::TCCFG_WM_NORMAL && ctrl_reg.channel_enable[k]) ?
               wg_reg[k] : PORT_OUT[k];
         end
         ovf_out_reg <= flag_point;
         input_capture_action_out_reg <= cap_hit;
      end
   end

   // Read data one cycle after the strobe
   always_ff @(posedge CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         RDATA <= '0;
      end else if (RD) begin
         case (ADDR)
            `TCCFG_OFF_CLK: RDATA <= {12'h000, ctrl_reg.clock_source_sel};
            `TCCFG_OFF_WAVE: RDATA <= {8'h00, ctrl_reg.channel_enable, 1'b0, ctrl_reg.wave_mode};
            `TCCFG_OFF_CMP: RDATA <= {12'h000, ctrl_reg.direct_output_value};
            `TCCFG_OFF_EVT: RDATA <= {8'h00, ctrl_reg.event_action, ctrl_reg.event_delay,
               ctrl_reg.event_source_sel};
            `TCCFG_OFF_PER: RDATA <= per_reg;
            `TCCFG_OFF_CCA: RDATA <= is_capture ? cap_reg[0] : cca_reg;
            `TCCFG_OFF_CNT: RDATA <= cnt_reg;
            `TCCFG_OFF_STAT: RDATA <= {7'h00, dir_reg, capv_reg, wg_reg[3:2], error_flag_reg,
               overflow_flag_reg};
            default: RDATA <= '0;
         endcase
      end else begin
         RDATA <= '0;
      end
   end

   assign WAVE_OUTPUT_PIN = pin_reg;
   assign OVERFLOW_EVENT = ovf_out_reg;
   assign CAPTURE_EVENT = input_capture_action_out_reg;

   // Checks
   sequence restart_req_s;
      restart;
   endsequence
   sequence cleared_s;
      cnt_reg == 16'h0000 && !dir_reg && wg_reg == 4'h0;
   endsequence

   off_no_count_a: assert property (@(posedge CLK) disable iff (!rst_n_reg)
      !running && !restart |=> $stable(cnt_reg))
      else $error("counter moved while off");
   restart_clear_a: assert property (@(posedge CLK) disable iff (!rst_n_reg)
      restart_req_s |=> cleared_s)
      else $error("restart did not clear");
   direct_out_a: assert property (@(posedge CLK) disable iff (!rst_n_reg)
      !running && !restart && WR && ADDR == `TCCFG_OFF_CMP |=> wg_reg == $past(WDATA[3:0]))
      else $error("direct output not applied");
   pin_normal_a: assert property (@(posedge CLK) disable iff (!rst_n_reg)
      wmode == tccfg_pkg::TCCFG_WM_NORMAL && $stable(wmode) |=> pin_reg == $past(PORT_OUT))
      else $error("pin overridden in normal mode");
   div1_tick_a: assert property (@(posedge CLK) disable iff (!rst_n_reg)
      ctrl_reg.clock_source_sel == 4'h1 |-> cnt_tick)
      else $error("divide by one missed tick");
   ovf_event_a: assert property (@(posedge CLK) disable iff (!rst_n_reg)
      flag_point |=> ovf_out_reg && overflow_flag_reg)
      else $error("overflow not flagged");
   reserved_mode_a: assert property (@(posedge CLK) disable iff (!rst_n_reg)
      ctrl_reg.wave_mode == 3'h2 |-> wmode == tccfg_pkg::TCCFG_WM_NORMAL)
      else $error("reserved mode not normal");
   no_action_a: assert property (@(posedge CLK) disable iff (!rst_n_reg)
      ctrl_reg.event_action == 3'h0 |-> chan_event == 4'h0 ##1 input_capture_action_out_reg == 4'h0)
      else $error("event routed with no action");
   freq_top_a: assert property (@(posedge CLK) disable iff (!rst_n_reg)
      wmode == tccfg_pkg::TCCFG_WM_FREQ && cnt_tick && !dir_reg && cnt_reg == cca_reg |-> flag_point)
      else $error("frequency top not compare A");
   off_hold_a: assert property (@(posedge CLK) disable iff (!rst_n_reg)
      !running && !restart && !(WR && ADDR == `TCCFG_OFF_CMP) |=> $stable(wg_reg))
      else $error("outputs moved while off");
   two_bottom_a: assert property (@(posedge CLK) disable iff (!rst_n_reg)
      two_ramp && at_bottom && !restart && ctrl_reg.event_action == 3'h0 |=> cnt_reg == 16'h0001 && !dir_reg)
      else $error("two-ramp bottom not turned");
   overrun_err_a: assert property (@(posedge CLK) disable iff (!rst_n_reg)
      |(cap_hit & capv_reg) |=> error_flag_reg)
      else $error("capture overrun not flagged");
endmodule

// ==== testbench/tccfg_event_src.sv ====
// Event channel and port register model facing the timer
`timescale 1ns/1ps
module tccfg_event_src (
   // Clock
   input wire logic clk,
   // Far-side signals
   output logic [7:0] events,
   output logic [3:0] port_out
);
   initial begin
      events = 8'h00;
      port_out = 4'h5;
   end
   // Held three cycles so the two-flop synchroniser cannot miss it
   task automatic pulse(input int ch);
      begin
         @(posedge clk);
         events[ch] <= 1'b1;
         repeat (3) @(posedge clk);
         events[ch] <= 1'b0;
         @(posedge clk);
      end
   endtask
endmodule

// ==== testbench/testbench.sv ====
// Self-checking bench for the timer control block
`timescale 1ns/1ps
module testbench;
   typedef struct packed {
      logic [7:0] r0;
      logic [7:0] r1;
      logic [15:0] gap;
   } tccfg_row_s;
   localparam int LIMIT = 60000;
   localparam logic [15:0] MASKS [4] = '{16'h000F, 16'h00F7, 16'h000F, 16'h00FF};
   // Period 3 and compare A 1 give these overflow spacings
   localparam tccfg_row_s ROWS [15] = '{
      '{8'h01, 8'h00, 16'h0004},
      '{8'h02, 8'h00, 16'h0008},
      '{8'h03, 8'h00, 16'h0010},
      '{8'h04, 8'h00, 16'h0020},
      '{8'h05, 8'h00, 16'h0100},
      '{8'h06, 8'h00, 16'h0400},
      '{8'h07, 8'h00, 16'h1000},
      '{8'h01, 8'h01, 16'h0002},
      '{8'h01, 8'h03, 16'h0004},
      '{8'h01, 8'h05, 16'h0006},
      '{8'h01, 8'h06, 16'h0003},
      '{8'h01, 8'h07, 16'h0006},
      '{8'h01, 8'h02, 16'h0004},
      '{8'h01, 8'h04, 16'h0004},
      '{8'h00, 8'h00, 16'h0000}
   };
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [15:0] rdata;
   logic [7:0] ev;
   logic [3:0] port;
   logic [3:0] pins;
   logic [3:0] cap;
   logic ovf;
   int bad_count = 0;
   int n_tests = 0;
   int cycles = 0;

   tccfg_event_src src (.clk(clk), .events(ev), .port_out(port));
   tccfg_top uut (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .EVENT_CH(ev), .PORT_OUT(port), .WAVE_OUTPUT_PIN(pins), .OVERFLOW_EVENT(ovf), .CAPTURE_EVENT(cap));

   always #2.5 clk = ~clk;

   task automatic print_verdict;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, bad_count);
         if (bad_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
         end else begin
            $display("[ FAIL ]");
         end
         $finish;
      end
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         bad_count++;
         print_verdict();
      end
   end

   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      begin
         n_tests++;
         if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
         end
      end
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      begin
         @(posedge clk);
         addr <= a;
         wdata <= d;
         wr <= 1'b1;
         @(posedge clk);
         wr <= 1'b0;
      end
   endtask

   task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
      begin
         @(posedge clk);
         addr <= a;
         rd <= 1'b1;
         @(posedge clk);
         rd <= 1'b0;
         @(negedge clk);
         d = rdata;
      end
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
      logic [15:0] d;
      begin
         rd_reg(a, d);
         check(d, e, "register read");
      end
   endtask

   // Spacing between two overflow pulses, zero if none comes
   task automatic gap_of(output logic [15:0] g);
      int n;
      begin
         g = 16'h0000;
         @(negedge clk);
         for (n = 0; n < 5000 && ovf !== 1'b1; n++) @(negedge clk);
         // First pulse may be left over from the mode in force before the restart
         @(negedge clk);
         for (n = 0; n < 5000 && ovf !== 1'b1; n++) @(negedge clk);
         if (ovf === 1'b1) begin
            for (n = 1; n < 5000; n++) begin
               @(negedge clk);
               if (ovf === 1'b1) break;
            end
            g = n[15:0];
         end
      end
   endtask

   task automatic cap_of(input int ch, output logic [3:0] c, output int lat);
      begin
         c = 4'h0;
         fork
            src.pulse(ch);
            begin
               @(posedge clk);
               for (lat = 0; lat < 20 && c === 4'h0; lat++) begin
                  @(negedge clk);
                  c = cap;
               end
            end
         join
      end
   endtask

   initial begin
      logic [15:0] g;
      logic [3:0] c;
      int lat0;
      int lat1;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 4; i++) rd_chk(i[3:0], 16'h0000);
      for (int i = 9; i < 16; i++) rd_chk(i[3:0], 16'h0000);
      check({12'h000, pins}, {12'h000, port}, "pins after reset");
      // Reserved bits written as ones on purpose, then an unmapped write
      for (int i = 0; i < 4; i++) wr_reg(i[3:0], 16'h00FF);
      wr_reg(4'hF, 16'h0000);
      for (int i = 0; i < 4; i++) rd_chk(i[3:0], MASKS[i]);
      for (int i = 0; i < 4; i++) wr_reg(i[3:0], 16'h0000);
      wr_reg(4'h5, 16'h0003);
      wr_reg(4'h6, 16'h0001);
      foreach (ROWS[i]) begin
         wr_reg(4'h1, {8'h00, ROWS[i].r1});
         wr_reg(4'h0, {8'h00, ROWS[i].r0});
         wr_reg(4'h4, 16'h0002);
         gap_of(g);
         check(g, ROWS[i].gap, "overflow spacing");
      end
      wr_reg(4'h2, 16'h000A);
      wr_reg(4'h1, 16'h00F1);
      repeat (3) @(negedge clk);
      check({12'h000, pins}, 16'h000A, "direct outputs");
      wr_reg(4'h4, 16'h0002);
      repeat (3) @(negedge clk);
      check({12'h000, pins}, 16'h0000, "outputs after restart");
      wr_reg(4'h2, 16'h000A);
      wr_reg(4'h1, 16'h0031);
      repeat (3) @(negedge clk);
      check({12'h000, pins}, {12'h000, port[3:2], 2'h2}, "partial enable");
      wr_reg(4'h1, 16'h00F0);
      repeat (3) @(negedge clk);
      check({12'h000, pins}, {12'h000, port}, "normal mode pins");
      // Counting on event channel 2 only
      wr_reg(4'h0, 16'h000A);
      wr_reg(4'h4, 16'h0002);
      src.pulse(2);
      src.pulse(2);
      src.pulse(3);
      rd_chk(4'h7, 16'h0002);
      wr_reg(4'h4, 16'h0002);
      rd_chk(4'h7, 16'h0000);
      for (int a = 0; a < 8; a++) begin
         wr_reg(4'h3, {8'h00, a[2:0], 5'h0E});
         rd_chk(4'h3, {8'h00, a[2:0], 5'h0E});
      end
      wr_reg(4'h0, 16'h0001);
      wr_reg(4'h3, 16'h002E);
      rd_reg(4'h8, g);
      // Base channel 6 so the rotation wraps past 7
      for (int k = 0; k < 4; k++) begin
         cap_of((6 + k) % 8, c, lat0);
         check({12'h000, c}, 16'h0001 << k, "capture channel");
      end
      cap_of(6, c, lat0);
      rd_reg(4'h8, g);
      check(g & 16'h0012, 16'h0012, "capture overrun");
      rd_reg(4'h8, g);
      check(g & 16'h0002, 16'h0000, "error cleared");
      wr_reg(4'h3, 16'h003E);
      cap_of(6, c, lat1);
      check(16'(lat1), 16'(lat0 + 1), "delayed capture");
      wr_reg(4'h3, 16'h002E);
      wr_reg(4'h1, 16'h0010);
      cap_of(7, c, lat1);
      check({12'h000, c}, 16'h0000, "disabled channel");
      wr_reg(4'h1, 16'h00F0);
      wr_reg(4'h3, 16'h000E);
      cap_of(6, c, lat1);
      check({12'h000, c}, 16'h0000, "no action");
      wr_reg(4'h3, 16'h00EE);
      cap_of(6, c, lat1);
      check({12'h000, c}, 16'h0000, "reserved action");
      wr_reg(4'h3, 16'h0020);
      cap_of(0, c, lat1);
      check({12'h000, c}, 16'h0000, "no source");
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      rd_chk(4'h1, 16'h0000);
      rd_chk(4'h3, 16'h0000);
      print_verdict();
   end
endmodule
